/* File: src/cmt_params.svh */
// register offsets, field positions and reset values of the capture/match timer
`ifndef CMT_PARAMS_SVH
`define CMT_PARAMS_SVH

// byte offsets on the wishbone bus
`define CMT_OFF_CTRL   8'h00
`define CMT_OFF_TC     8'h04
`define CMT_OFF_PR     8'h08
`define CMT_OFF_PC     8'h0C
`define CMT_OFF_MCTRL  8'h10
`define CMT_OFF_OUTC   8'h14
`define CMT_OFF_CAPC   8'h18
`define CMT_OFF_STAT   8'h1C
`define CMT_OFF_MASK   8'h20
`define CMT_OFF_MATCH0 8'h24
`define CMT_OFF_CAP0   8'h34

// control register bits
`define CMT_CTRL_EN     0
`define CMT_CTRL_RST    1
`define CMT_CTRL_CLKRUN 2
`define CMT_CTRL_PAUSE  3
`define CMT_CTRL_W      4
`define CMT_CTRL_RESET  4'h4

// match control: three bits per match channel
`define CMT_MC_INT  0
`define CMT_MC_RST  1
`define CMT_MC_STOP 2
`define CMT_MC_W    3

// capture control: three bits per capture channel
`define CMT_CC_RISE 0
`define CMT_CC_FALL 1
`define CMT_CC_INT  2
`define CMT_CC_W    3

// output control: levels in low nibble, two action bits per channel above
`define CMT_OC_ACT 4

// status/mask: match flags low nibble, capture flags high nibble
`define CMT_ST_CAP 4

`endif

/* File: src/cmt_pkg.sv */
// types shared by the capture/match timer modules
package cmt_pkg;

  // action on a compare output pin when its match hits
  typedef enum logic [1:0] {
    CMT_ACT_NONE,
    CMT_ACT_LOW,
    CMT_ACT_HIGH,
    CMT_ACT_TOGGLE
  } cmt_act_t;

  typedef logic [3:0][31:0] cmt_word4_t;

endpackage

/* File: src/cmt_capture.sv */
// capture channels: edge detect on snapshot pins and capture registers
`timescale 1ns/10ps
module cmt_capture
  import cmt_pkg::*;
#(
  parameter int CH = 4
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // pins and configuration
  input  wire logic [CH-1:0] snap_i,
  input  wire logic [CH-1:0] rise_en_i,
  input  wire logic [CH-1:0] fall_en_i,
  input  wire logic [31:0]   tc_i,
  // results
  output logic [CH-1:0]      evt_o,
  output cmt_word4_t         cap_o
);

  logic [CH-1:0] prev_reg;
  logic [CH-1:0] prev_next;
  logic [31:0]   cap_reg  [CH];
  logic [31:0]   cap_next [CH];

  // a state change on a pin copies the counter value
  always_comb begin
    prev_next = snap_i;
    for (int i = 0; i < CH; i++) begin
      evt_o[i]    = (rise_en_i[i] & snap_i[i] & ~prev_reg[i]) |
                    (fall_en_i[i] & ~snap_i[i] & prev_reg[i]);
      cap_next[i] = evt_o[i] ? tc_i : cap_reg[i];
      cap_o[i]    = cap_reg[i];
    end
  end

  // prev starts at zero so a pin high at reset release reads as a rise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_reg <= '0;
      for (int i = 0; i < CH; i++) begin
        cap_reg[i] <= 32'h0000_0000;
      end
    end else begin
      prev_reg <= prev_next;
      for (int i = 0; i < CH; i++) begin
        cap_reg[i] <= cap_next[i];
      end
    end
  end

endmodule // cmt_capture

/* File: src/cmt_match.sv */
// match comparators and compare output pin actions
`timescale 1ns/10ps
module cmt_match
  import cmt_pkg::*;
#(
  parameter int CH = 4
) (
  // clock and reset
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  // counter and configuration
  input  wire logic            tick_i,
  input  wire logic [31:0]     tc_i,
  input  wire cmt_word4_t      match_i,
  input  wire logic [2*CH-1:0] act_i,
  // software write of pin levels
  input  wire logic            lvl_wr_i,
  input  wire logic [CH-1:0]   lvl_i,
  // results
  output logic [CH-1:0]        hit_o,
  output logic [CH-1:0]        pin_o
);

  logic [CH-1:0] pin_reg;
  logic [CH-1:0] pin_next;
  cmt_act_t      act;

  // compare on the prescale tick so a match acts once per count value
  always_comb begin
    pin_next = lvl_wr_i ? lvl_i : pin_reg;
    act      = CMT_ACT_NONE;
    for (int i = 0; i < CH; i++) begin
      hit_o[i] = tick_i & (tc_i == match_i[i]);
      act      = cmt_act_t'(act_i[2*i +: 2]);
      if (hit_o[i]) begin
        unique case (act)
          CMT_ACT_NONE:   pin_next[i] = pin_reg[i];
          CMT_ACT_LOW:    pin_next[i] = 1'b0;
          CMT_ACT_HIGH:   pin_next[i] = 1'b1;
          CMT_ACT_TOGGLE: pin_next[i] = ~pin_reg[i];
        endcase
      end
    end
  end

  // pin levels; a match action wins over a software write in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_reg <= '0;
    end else begin
      pin_reg <= pin_next;
    end
  end

  assign pin_o = pin_reg;

endmodule // cmt_match

/* File: src/cmt_timer.sv */
// capture/match timer top: wishbone slave, prescaler, counter, interrupts
//
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/10ps
`include "cmt_params.svh"

// Overview of operation
// - prescale terminal count advances timer counter
// - software sets full 32-bit prescale value
// - both counters run on timer clock
// - register side synchronised with counter side
// - timer branch clock gateable by software
// - four channels capture count on pin change
// - capture interrupt optional per channel enable
// - four match registers compared with counter
// - continuous mode keeps counting, optional interrupt
// - stop mode halts both counters on match
// - reset mode zeroes counter, keeps counting
// - four compare output pins, one per match
// - pin goes low, high, toggles or holds
// - pause input freezes counting while asserted
module cmt_timer
  import cmt_pkg::*;
#(
  parameter int CH = 4
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // wishbone slave
  input  wire logic [7:0]    adr_i,
  input  wire logic [31:0]   dat_i,
  input  wire logic [3:0]    sel_i,
  input  wire logic          we_i,
  input  wire logic          cyc_i,
  input  wire logic          stb_i,
  output logic [31:0]        dat_o,
  output logic               ack_o,
  // pins
  input  wire logic [CH-1:0] snapshot_input_pin_i,
  input  wire logic          pause_i,
  output logic [CH-1:0]      compare_output_pin_o,
  // interrupt
  output logic               irq_o
);

  // byte-lane merge of a write into a register
  function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // word slot decode of per-channel registers, shared by write and read paths
  function automatic logic slot_hit(input logic [7:0] adr,
                                    input logic [7:0] base,
                                    input int         idx);
    return adr == (base + 8'(4*idx));
  endfunction

  logic [`CMT_CTRL_W-1:0]     ctrl_reg,  ctrl_next;
  logic [31:0]                tc_reg,    tc_next;
  logic [31:0]                pr_reg,    pr_next;
  logic [31:0]                pc_reg,    pc_next;
  logic [`CMT_MC_W*CH-1:0]    mctrl_reg, mctrl_next;
  logic [2*CH-1:0]            act_reg,   act_next;
  logic [`CMT_CC_W*CH-1:0]    capc_reg,  capc_next;
  logic [2*CH-1:0]            stat_reg,  stat_next;
  logic [2*CH-1:0]            mask_reg,  mask_next;
  cmt_word4_t                 match_reg, match_next;
  logic [31:0]                dat_reg,   dat_next;
  logic                       ack_reg,   ack_next;
  logic                       irq_reg,   irq_next;

  logic                       acc;
  logic                       wr;
  logic [31:0]                wmask;
  logic                       counting;
  logic                       tick;
  logic [CH-1:0]              hit;
  logic [CH-1:0]              cap_evt;
  cmt_word4_t                 cap_val;
  logic [CH-1:0]              pin_lvl;
  logic [CH-1:0]              rise_en, fall_en, cap_int, m_int, m_rst, m_stop;
  logic [2*CH-1:0]            irq_en;
  logic [31:0]                rd_lvl;

  // unpack per-channel configuration fields
  always_comb begin
    for (int i = 0; i < CH; i++) begin
      rise_en[i] = capc_reg[`CMT_CC_W*i + `CMT_CC_RISE];
      fall_en[i] = capc_reg[`CMT_CC_W*i + `CMT_CC_FALL];
      cap_int[i] = capc_reg[`CMT_CC_W*i + `CMT_CC_INT];
      m_int[i]   = mctrl_reg[`CMT_MC_W*i + `CMT_MC_INT];
      m_rst[i]   = mctrl_reg[`CMT_MC_W*i + `CMT_MC_RST];
      m_stop[i]  = mctrl_reg[`CMT_MC_W*i + `CMT_MC_STOP];
    end
  end

  // counting is gated by enable, branch clock run, hold and pause
  assign counting = ctrl_reg[`CMT_CTRL_EN] & ctrl_reg[`CMT_CTRL_CLKRUN]
                  & ~ctrl_reg[`CMT_CTRL_RST]
                  & ~(ctrl_reg[`CMT_CTRL_PAUSE] & pause_i);
  assign tick     = counting & (pc_reg == pr_reg);

  // bus handshake; one wait state, ack drops the cycle after it rose
  // a request still held in the ack cycle is not taken twice
  assign acc   = cyc_i & stb_i & ~ack_reg;
  assign wr    = acc & we_i;
  assign wmask = wb_merge(32'h0000_0000, 32'hFFFF_FFFF, sel_i);

  // pin levels live in the low byte lane of the output control word
  cmt_match #(
    .CH (CH)
  ) u_match (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .tick_i   (tick),
    .tc_i     (tc_reg),
    .match_i  (match_reg),
    .act_i    (act_reg),
    .lvl_wr_i (wr && adr_i == `CMT_OFF_OUTC && sel_i[0]),
    .lvl_i    (dat_i[CH-1:0]),
    .hit_o    (hit),
    .pin_o    (pin_lvl)
  );

  cmt_capture #(
    .CH (CH)
  ) u_capture (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .snap_i    (snapshot_input_pin_i),
    .rise_en_i (rise_en),
    .fall_en_i (fall_en),
    .tc_i      (tc_reg),
    .evt_o     (cap_evt),
    .cap_o     (cap_val)
  );

  // counters: prescaler wraps at the programmed value and ticks the timer
  always_comb begin
    ctrl_next = ctrl_reg;
    pc_next   = pc_reg;
    tc_next   = tc_reg;
    // hold-in-reset outranks counting so software can zero both counters
    if (ctrl_reg[`CMT_CTRL_RST]) begin
      pc_next = 32'h0000_0000;
      tc_next = 32'h0000_0000;
    end else if (counting) begin
      pc_next = tick ? 32'h0000_0000 : pc_reg + 32'h0000_0001;
      // a stop match freezes the count at the match value; reset outranks stop
      if (tick) begin
        if (|(hit & m_rst)) begin
          tc_next = 32'h0000_0000;
        end else if (!(|(hit & m_stop))) begin
          tc_next = tc_reg + 32'h0000_0001;
        end
      end
      if (|(hit & m_stop)) begin
        ctrl_next[`CMT_CTRL_EN] = 1'b0;
      end
    end
    // software writes land last and win over the counters, so an enable
    // written in the cycle of a stop match leaves the timer running
    if (wr && adr_i == `CMT_OFF_CTRL) begin
      ctrl_next = (dat_i[`CMT_CTRL_W-1:0] & wmask[`CMT_CTRL_W-1:0])
                | (ctrl_reg & ~wmask[`CMT_CTRL_W-1:0]);
    end
    if (wr && adr_i == `CMT_OFF_TC) begin
      tc_next = wb_merge(tc_reg, dat_i, sel_i);
    end
    if (wr && adr_i == `CMT_OFF_PC) begin
      pc_next = wb_merge(pc_reg, dat_i, sel_i);
    end
  end

  // configuration registers and sticky flags
  always_comb begin
    pr_next    = pr_reg;
    mctrl_next = mctrl_reg;
    act_next   = act_reg;
    capc_next  = capc_reg;
    mask_next  = mask_reg;
    match_next = match_reg;
    stat_next  = stat_reg;
    if (wr) begin
      if (adr_i == `CMT_OFF_PR) begin
        pr_next = wb_merge(pr_reg, dat_i, sel_i);
      end
      if (adr_i == `CMT_OFF_MCTRL) begin
        mctrl_next = (dat_i[`CMT_MC_W*CH-1:0] & wmask[`CMT_MC_W*CH-1:0])
                   | (mctrl_reg & ~wmask[`CMT_MC_W*CH-1:0]);
      end
      if (adr_i == `CMT_OFF_OUTC) begin
        act_next = (dat_i[`CMT_OC_ACT +: 2*CH] & wmask[`CMT_OC_ACT +: 2*CH])
                 | (act_reg & ~wmask[`CMT_OC_ACT +: 2*CH]);
      end
      if (adr_i == `CMT_OFF_CAPC) begin
        capc_next = (dat_i[`CMT_CC_W*CH-1:0] & wmask[`CMT_CC_W*CH-1:0])
                  | (capc_reg & ~wmask[`CMT_CC_W*CH-1:0]);
      end
      if (adr_i == `CMT_OFF_MASK) begin
        mask_next = (dat_i[2*CH-1:0] & wmask[2*CH-1:0])
                  | (mask_reg & ~wmask[2*CH-1:0]);
      end
      if (adr_i == `CMT_OFF_STAT) begin
        stat_next = stat_reg & ~(dat_i[2*CH-1:0] & wmask[2*CH-1:0]);
      end
      // capture words are read only; writes to them are dropped
      for (int i = 0; i < CH; i++) begin
        if (slot_hit(adr_i, `CMT_OFF_MATCH0, i)) begin
          match_next[i] = wb_merge(match_reg[i], dat_i, sel_i);
        end
      end
    end
    // a new event wins over a clear in the same cycle
    stat_next = stat_next | {cap_evt, hit};
  end

  // read mux, ack and interrupt
  always_comb begin
    rd_lvl   = 32'h0000_0000;
    rd_lvl[CH-1:0] = pin_lvl;
    rd_lvl[`CMT_OC_ACT +: 2*CH] = act_reg;
    dat_next = 32'h0000_0000;
    unique case (adr_i)
      `CMT_OFF_CTRL:  dat_next = {28'h0000000, ctrl_reg};
      `CMT_OFF_TC:    dat_next = tc_reg;
      `CMT_OFF_PR:    dat_next = pr_reg;
      `CMT_OFF_PC:    dat_next = pc_reg;
      `CMT_OFF_MCTRL: dat_next = {20'h00000, mctrl_reg};
      `CMT_OFF_OUTC:  dat_next = rd_lvl;
      `CMT_OFF_CAPC:  dat_next = {20'h00000, capc_reg};
      `CMT_OFF_STAT:  dat_next = {24'h000000, stat_reg};
      `CMT_OFF_MASK:  dat_next = {24'h000000, mask_reg};
      // unmapped and unaligned addresses read as zero
      default: begin
        for (int i = 0; i < CH; i++) begin
          if (slot_hit(adr_i, `CMT_OFF_MATCH0, i)) begin
            dat_next = match_reg[i];
          end
          if (slot_hit(adr_i, `CMT_OFF_CAP0, i)) begin
            dat_next = cap_val[i];
          end
        end
      end
    endcase
    if (!acc) begin
      dat_next = dat_reg;
    end
    ack_next = acc;
    // flags set whatever the enables; enables and mask only gate the line
    irq_en   = {cap_int, m_int};
    irq_next = |(stat_next & mask_reg & irq_en);
  end

  // single clock: register writes reach the counters on the next edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg  <= `CMT_CTRL_RESET;
      tc_reg    <= 32'h0000_0000;
      pr_reg    <= 32'h0000_0000;
      pc_reg    <= 32'h0000_0000;
      mctrl_reg <= '0;
      act_reg   <= '0;
      capc_reg  <= '0;
      stat_reg  <= '0;
      mask_reg  <= '0;
      match_reg <= '0;
      dat_reg   <= 32'h0000_0000;
      ack_reg   <= 1'b0;
      irq_reg   <= 1'b0;
    end else begin
      ctrl_reg  <= ctrl_next;
      tc_reg    <= tc_next;
      pr_reg    <= pr_next;
      pc_reg    <= pc_next;
      mctrl_reg <= mctrl_next;
      act_reg   <= act_next;
      capc_reg  <= capc_next;
      stat_reg  <= stat_next;
      mask_reg  <= mask_next;
      match_reg <= match_next;
      dat_reg   <= dat_next;
      ack_reg   <= ack_next;
      irq_reg   <= irq_next;
    end
  end

  assign dat_o                = dat_reg;
  assign ack_o                = ack_reg;
  assign irq_o                = irq_reg;
  assign compare_output_pin_o = pin_lvl;

endmodule // cmt_timer

/* File: verif/cmt_timer_chk.sv */
// concurrent port checks for the capture/match timer
`timescale 1ns/10ps
module cmt_timer_chk #(
  parameter int CH = 4
) (
  // clock and reset
  input wire logic          clk_i,
  input wire logic          rst_i,
  // wishbone slave
  input wire logic [7:0]    adr_i,
  input wire logic [31:0]   dat_i,
  input wire logic [3:0]    sel_i,
  input wire logic          we_i,
  input wire logic          cyc_i,
  input wire logic          stb_i,
  input wire logic [31:0]   dat_o,
  input wire logic          ack_o,
  // pins and interrupt
  input wire logic [CH-1:0] snapshot_input_pin_i,
  input wire logic          pause_i,
  input wire logic [CH-1:0] compare_output_pin_o,
  input wire logic          irq_o
);
  // one clock domain, so one default for all checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_wait: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing one cycle after request");
  chk_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  chk_dat_hold: assert property (!(cyc_i && stb_i && !ack_o) |=> $stable(dat_o))
    else $error("read data moved without access");
  chk_unmapped_zero: assert property (cyc_i && stb_i && !we_i && !ack_o && adr_i > 8'h40 |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_mask_off: assert property (cyc_i && stb_i && we_i && !ack_o && adr_i == 8'h20 && sel_i == 4'hF
    && dat_i == 32'h0 |=> ##1 !irq_o)
    else $error("interrupt high with all masked");
  chk_irq_fall: assert property ($fell(irq_o) |-> $past(cyc_i && stb_i && we_i)
    || $past(cyc_i && stb_i && we_i, 2))
    else $error("interrupt fell without a write");
  // reset itself must be watched, so this one ignores the default disable
  chk_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !ack_o && !irq_o
    && compare_output_pin_o == '0 && dat_o == 32'h0)
    else $error("outputs active in reset");
endmodule // cmt_timer_chk

bind cmt_timer cmt_timer_chk #(.CH(CH)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .snapshot_input_pin_i(snapshot_input_pin_i),
  .pause_i(pause_i), .compare_output_pin_o(compare_output_pin_o), .irq_o(irq_o));

/* File: verif/cmt_pins.sv */
// pin-side model: snapshot sources and the pause driver
`timescale 1ns/10ps
module cmt_pins (
  // clock
  input  wire logic       clk_i,
  // commands from the bench
  input  wire logic [3:0] snap_cmd_i,
  input  wire logic       pause_cmd_i,
  // pins toward the timer
  output logic [3:0]      snapshot_input_pin_o,
  output logic            pause_o
);
  // quiet levels from time zero, before any edge
  initial begin
    snapshot_input_pin_o = 4'h0;
    pause_o = 1'b0;
  end

  // pins move one edge after the command, like a clocked source
  always @(posedge clk_i) begin
    snapshot_input_pin_o <= snap_cmd_i;
    pause_o <= pause_cmd_i;
  end
endmodule // cmt_pins

/* File: verif/cmt_timer_tb.sv */
// self-checking bench for the capture/match timer
`timescale 1ns/10ps
`include "cmt_params.svh"
module cmt_timer_tb
  import cmt_pkg::*;
;
  logic        clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, irq_o, pause_cmd, pause_w;
  logic [7:0]  adr_i;
  logic [31:0] dat_i, dat_o, rd, seed;
  logic [3:0]  sel_i, snap_cmd, snap_w, pins_w, wsel;
  int          fails, compares;

  cmt_timer #(.CH(4)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .snapshot_input_pin_i(snap_w),
    .pause_i(pause_w), .compare_output_pin_o(pins_w), .irq_o(irq_o));
  cmt_pins u_pins (.clk_i(clk_i), .snap_cmd_i(snap_cmd), .pause_cmd_i(pause_cmd),
    .snapshot_input_pin_o(snap_w), .pause_o(pause_w));

  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected compare pin level after a match
  function automatic logic act_exp(input logic l, input logic [1:0] a);
    case (a)
      CMT_ACT_LOW: return 1'b0;
      CMT_ACT_HIGH: return 1'b1;
      CMT_ACT_TOGGLE: return ~l;
      default: return l;
    endcase
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // classic cycle; entered just after an edge, returns after one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= wsel;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic final_report;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog: whole run is well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    final_report();
  end

  initial begin
    int k, m, p, n;
    logic l;
    logic [31:0] v;
    {fails, compares, m} = '0;
    seed = 32'h0000B27F;
    {rst_i, we_i, cyc_i, stb_i, pause_cmd} = 5'h10;
    {adr_i, dat_i, sel_i, snap_cmd} = '0;
    wsel = 4'hF;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, `CMT_OFF_CTRL, 32'h0);
    check(rd, 32'(`CMT_CTRL_RESET));
    wb(1'b0, 8'h80, 32'h0);
    check(rd, 32'h0);
    // prescale: disable lands K+3 edges after enable
    for (int i = 0; i < 3; i++) begin
      p = rnd() % 8;
      k = rnd() % 32;
      wb(1'b1, `CMT_OFF_PR, p);
      wb(1'b1, `CMT_OFF_TC, 32'h0);
      wb(1'b1, `CMT_OFF_PC, 32'h0);
      wb(1'b1, `CMT_OFF_CTRL, 32'h5);
      repeat (k) @(posedge clk_i);
      wb(1'b1, `CMT_OFF_CTRL, 32'h4);
      wb(1'b0, `CMT_OFF_TC, 32'h0);
      check(rd, 32'((k + 3) / (p + 1)));
      wb(1'b0, `CMT_OFF_PC, 32'h0);
      check(rd, 32'((k + 3) % (p + 1)));
    end
    // stop on match with each pin action
    wb(1'b1, `CMT_OFF_MCTRL, 32'h5);
    wb(1'b1, `CMT_OFF_MASK, 32'h1);
    wb(1'b1, `CMT_OFF_PR, 32'h0);
    // a prescale count left above the new value would stall every tick
    wb(1'b1, `CMT_OFF_PC, 32'h0);
    for (int a = 0; a < 4; a++) begin
      m = rnd() % 6 + 1;
      l = m[1];
      wb(1'b1, `CMT_OFF_OUTC, {26'h0, a[1:0], 3'h0, l});
      wb(1'b1, `CMT_OFF_STAT, 32'hFF);
      wb(1'b1, `CMT_OFF_MATCH0, m);
      wb(1'b1, `CMT_OFF_TC, 32'h0);
      wb(1'b1, `CMT_OFF_CTRL, 32'h5);
      n = 0;
      while (irq_o !== 1'b1 && n < 50) begin
        @(posedge clk_i);
        n++;
      end
      wb(1'b0, `CMT_OFF_TC, 32'h0);
      check(rd, m);
      check({28'h0, pins_w}, {31'h0, act_exp(l, a[1:0])});
      wb(1'b0, `CMT_OFF_STAT, 32'h0);
      check(rd & 32'h1, 32'h1);
      wb(1'b1, `CMT_OFF_STAT, 32'h1);
      check({31'h0, irq_o}, 32'h0);
    end
    // continuous keeps counting past the match, reset wraps to zero
    for (int r = 0; r < 2; r++) begin
      wb(1'b1, `CMT_OFF_MCTRL, 32'(2 * r));
      wb(1'b1, `CMT_OFF_TC, 32'h0);
      wb(1'b1, `CMT_OFF_CTRL, 32'h5);
      repeat (20) @(posedge clk_i);
      wb(1'b1, `CMT_OFF_CTRL, 32'h4);
      wb(1'b0, `CMT_OFF_TC, 32'h0);
      check({31'h0, rd <= m}, 32'(r));
    end
    // capture on rising then falling edges, counter frozen at a known value
    for (int e = 0; e < 2; e++) begin
      wb(1'b1, `CMT_OFF_MASK, 32'hF0);
      wb(1'b1, `CMT_OFF_CAPC, e ? 32'h00000DB6 : 32'h00000B6D);
      v = rnd();
      wb(1'b1, `CMT_OFF_TC, v);
      snap_cmd <= e ? 4'h0 : 4'hF;
      repeat (4) @(posedge clk_i);
      for (int c = 0; c < 4; c++) begin
        wb(1'b0, 8'(`CMT_OFF_CAP0 + 4 * c), 32'h0);
        check(rd, v);
      end
      wb(1'b0, `CMT_OFF_STAT, 32'h0);
      check(rd & 32'hF0, 32'hF0);
      check({31'h0, irq_o}, 32'h1);
      wb(1'b1, `CMT_OFF_MASK, 32'h0);
      check({31'h0, irq_o}, 32'h0);
      wb(1'b1, `CMT_OFF_STAT, 32'hF0);
    end
    // pause honoured only when enabled; no count without clock run
    pause_cmd <= 1'b1;
    wb(1'b1, `CMT_OFF_MCTRL, 32'h0);
    for (int t = 0; t < 3; t++) begin
      wb(1'b1, `CMT_OFF_TC, 32'h0);
      wb(1'b1, `CMT_OFF_CTRL, t == 0 ? 32'hD : t == 1 ? 32'h1 : 32'h5);
      repeat (5) @(posedge clk_i);
      wb(1'b1, `CMT_OFF_CTRL, 32'h4);
      wb(1'b0, `CMT_OFF_TC, 32'h0);
      check(rd, t == 2 ? 32'h8 : 32'h0);
    end
    // byte lanes: only the selected lane lands in a match word
    wsel = 4'h2;
    wb(1'b1, 8'(`CMT_OFF_MATCH0 + 4), 32'h1234_5678);
    wsel = 4'hF;
    wb(1'b0, 8'(`CMT_OFF_MATCH0 + 4), 32'h0);
    check(rd, 32'h0000_5600);
    // hold-in-reset keeps the counter at zero although enabled and running
    wb(1'b1, `CMT_OFF_TC, 32'h0000_0055);
    wb(1'b1, `CMT_OFF_CTRL, 32'h7);
    repeat (3) @(posedge clk_i);
    wb(1'b1, `CMT_OFF_CTRL, 32'h4);
    wb(1'b0, `CMT_OFF_TC, 32'h0);
    check(rd, 32'h0);
    final_report();
  end
endmodule // cmt_timer_tb
